// file: design/cpn_node.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - frames carry at most eight bytes
// - identifier is function code over node
// - node number 1..127, zero rejected
// - system identifiers never used for PDOs
// - lower identifier wins, served first
// - transmit PDOs at 0x180..0x480 plus node
// - receive PDOs at 0x200..0x500 plus node
// - sync types send on received sync
// - type n sends every n syncs
// - types 254/255 send on data change
// - non-interpolation applies received data immediately
// - interpolation applies data at update point
// - inhibit time spaces sends, 1 ms units
// - async also sends at event interval
// - heartbeat 0x700 plus node, state byte
// - missing master heartbeat flags comm error
// - stop mode one gives alarm and stop
// - state codes 00, 04, 05, 7F
// - first heartbeat is the boot-up frame
// - after boot-up go pre-operational
module cpn_node #(
	parameter int unsigned MS_CYC = cpn_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Received frames
	input wire logic rx_valid_i,
	input wire cpn_pkg::cpn_frame_t rx_frame_i,
	// Transmitted frames
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output cpn_pkg::cpn_frame_t tx_frame_o,
	// Process data
	input wire logic [cpn_pkg::NPDO-1:0][63:0] tpdo_data_i,
	input wire logic interp_point_i,
	output logic [cpn_pkg::NPDO-1:0][63:0] rpdo_data_o,
	output logic [cpn_pkg::NPDO-1:0] rpdo_upd_o,
	// Status
	output logic [7:0] node_state_o,
	output logic comm_err_o,
	output logic alarm_o,
	output logic stop_o
);
	import cpn_pkg::*;

	logic [17:0] pre_reg;
	logic ms_tick;
	logic [6:0] node_reg;
	logic [6:0] master_reg;
	logic stop_en_reg;
	logic interp_reg;
	logic [15:0] hbp_reg;
	logic [15:0] hbc_reg;
	logic [7:0] ttype_reg [NPDO];
	logic [15:0] inh_cfg_reg [NPDO];
	logic [15:0] evt_cfg_reg [NPDO];
	cpn_nstate_t state_reg;
	logic [7:0] state_code;
	logic node_ok;
	logic is_oper;
	logic sync_rx;
	logic want_reg [NPDO];
	logic [16:0] inh_cnt_reg [NPDO];
	logic [NPDO-1:0] rdy;
	logic [NPDO-1:0] grant;
	logic [1:0] sel_pdo;
	logic pdo_any;
	logic load;
	logic hb_grant;
	logic hb_pend_reg;
	logic [15:0] hb_cnt_reg;
	logic hb_due;
	logic [15:0] cons_cnt_reg;
	logic cons_armed_reg;
	logic cons_expire;
	logic mhb_hit;
	logic comm_err_reg;
	logic alarm_reg;
	logic [3:0] rfc;
	logic [3:0] roff;
	logic [1:0] ridx;
	logic rpdo_hit;
	logic [63:0] rbuf_reg [NPDO];
	logic [NPDO-1:0] rpend_reg;
	logic status_clr;

	////////////////////////////////////////////////////////////////
	// Millisecond prescaler
	// prescaler tick
	assign ms_tick = (pre_reg == 18'(MS_CYC - 1));
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_reg <= '0;
		end else if (ms_tick) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 18'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			node_reg <= RST_NODE;
			master_reg <= RST_MASTER;
			stop_en_reg <= 1'b0;
			interp_reg <= 1'b0;
			hbp_reg <= RST_HBP;
			hbc_reg <= RST_HBC;
			for (int i = 0; i < NPDO; i++) begin
				ttype_reg[i] <= RST_TTYPE;
				inh_cfg_reg[i] <= '0;
				evt_cfg_reg[i] <= '0;
			end
		end else if (reg_wr_i) begin
			if (reg_addr_i == A_CTRL) begin
				node_reg <= reg_wdata_i[6:0];
				stop_en_reg <= reg_wdata_i[CTRL_STOPEN_BIT];
				interp_reg <= reg_wdata_i[CTRL_INTERP_BIT];
			end else if (reg_addr_i == A_HBP) begin
				hbp_reg <= reg_wdata_i[15:0];
			end else if (reg_addr_i == A_HBC) begin
				hbc_reg <= reg_wdata_i[15:0];
			end else if (reg_addr_i == A_MASTER) begin
				master_reg <= reg_wdata_i[6:0];
			end else if (reg_addr_i[7:4] == TPDO_PAGE) begin
				if (reg_addr_i[1:0] == F_TYPE) begin
					ttype_reg[reg_addr_i[3:2]] <= reg_wdata_i[7:0];
				end else if (reg_addr_i[1:0] == F_INH) begin
					inh_cfg_reg[reg_addr_i[3:2]] <= reg_wdata_i[15:0];
				end else if (reg_addr_i[1:0] == F_EVT) begin
					evt_cfg_reg[reg_addr_i[3:2]] <= reg_wdata_i[15:0];
				end
			end
		end
	end

	// Register reads, one cycle later, unmapped reads zero
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			if (reg_addr_i == A_CTRL) begin
				reg_rdata_o <= {23'h0, interp_reg, stop_en_reg, node_reg};
			end else if (reg_addr_i == A_STATE || reg_addr_i == A_STATUS) begin
				reg_rdata_o <= {21'h0, alarm_reg, ~node_ok, comm_err_reg, state_code};
			end else if (reg_addr_i == A_HBP) begin
				reg_rdata_o <= {16'h0, hbp_reg};
			end else if (reg_addr_i == A_HBC) begin
				reg_rdata_o <= {16'h0, hbc_reg};
			end else if (reg_addr_i == A_MASTER) begin
				reg_rdata_o <= {25'h0, master_reg};
			end else if (reg_addr_i[7:4] == TPDO_PAGE && reg_addr_i[1:0] == F_TYPE) begin
				reg_rdata_o <= {24'h0, ttype_reg[reg_addr_i[3:2]]};
			end else if (reg_addr_i[7:4] == TPDO_PAGE && reg_addr_i[1:0] == F_INH) begin
				reg_rdata_o <= {16'h0, inh_cfg_reg[reg_addr_i[3:2]]};
			end else if (reg_addr_i[7:4] == TPDO_PAGE && reg_addr_i[1:0] == F_EVT) begin
				reg_rdata_o <= {16'h0, evt_cfg_reg[reg_addr_i[3:2]]};
			end else begin
				reg_rdata_o <= '0;
			end
		end else begin
			reg_rdata_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Node state
	// zero node blocks all transmits and PDO reception
	assign node_ok = (node_reg != 7'h00);
	assign is_oper = (state_reg == NS_OPER);
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= NS_INIT;
		end else begin
			case (state_reg)
				NS_INIT: begin
					if (hb_grant) begin
						state_reg <= NS_PREOP;
					end
				end
				default: begin
					if (reg_wr_i && reg_addr_i == A_STATE) begin
						if (reg_wdata_i[7:0] == ST_OPER) begin
							state_reg <= NS_OPER;
						end else if (reg_wdata_i[7:0] == ST_STOP) begin
							state_reg <= NS_STOP;
						end else if (reg_wdata_i[7:0] == ST_PREOP) begin
							state_reg <= NS_PREOP;
						end
					end
				end
			endcase
		end
	end

	always_comb begin
		case (state_reg)
			NS_PREOP: state_code = ST_PREOP;
			NS_OPER: state_code = ST_OPER;
			NS_STOP: state_code = ST_STOP;
			default: state_code = ST_BOOT;
		endcase
	end
	assign node_state_o = state_code;

	////////////////////////////////////////////////////////////////
	// Transmit PDO triggers
	// sync on system identifier
	assign sync_rx = rx_valid_i && rx_frame_i.id == ID_SYNC && is_oper;
	for (genvar p = 0; p < NPDO; p++) begin : g_tpdo
		logic [7:0] sync_cnt_reg;
		logic [15:0] evt_cnt_reg;
		logic [63:0] prev_reg;
		logic changed;
		logic is_sync_t;
		logic is_async;
		logic sync_hit;
		logic evt_hit;
		assign changed = (tpdo_data_i[p] != prev_reg);
		assign is_sync_t = (ttype_reg[p] <= TT_SYNC_MAX);
		assign is_async = (ttype_reg[p] >= TT_ASYNC);
		// sync-driven send, type 0 on change
		assign sync_hit = sync_rx && is_sync_t &&
			((ttype_reg[p] == 8'h00) ? changed : (sync_cnt_reg == ttype_reg[p] - 8'h01));
		assign evt_hit = is_async && evt_cfg_reg[p] != 16'h0000 && evt_cnt_reg == 16'h0000;
		assign rdy[p] = want_reg[p] && inh_cnt_reg[p] == 17'h00000;
		assign grant[p] = load && pdo_any && sel_pdo == 2'(p);

		// Sync divider
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				sync_cnt_reg <= '0;
			end else if (!is_oper) begin
				sync_cnt_reg <= '0;
			end else if (sync_rx && is_sync_t) begin
				sync_cnt_reg <= (sync_cnt_reg + 8'h01 >= ttype_reg[p]) ? 8'h00 : sync_cnt_reg + 8'h01;
			end
		end

		// Send request, a new sync wins over the grant clear
		// data change request
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				want_reg[p] <= 1'b0;
			end else if (!is_oper) begin
				want_reg[p] <= 1'b0;
			end else begin
				want_reg[p] <= (want_reg[p] && !grant[p]) || sync_hit ||
					(is_async && (changed || evt_hit) && !grant[p]);
			end
		end

		// inhibit counter, one extra ms covers tick phase
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				inh_cnt_reg[p] <= '0;
			end else if (grant[p]) begin
				inh_cnt_reg[p] <= (inh_cfg_reg[p] == 16'h0000) ? 17'h00000 : {1'b0, inh_cfg_reg[p]} + 17'h00001;
			end else if (ms_tick && inh_cnt_reg[p] != 17'h00000) begin
				inh_cnt_reg[p] <= inh_cnt_reg[p] - 17'h00001;
			end
		end

		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				evt_cnt_reg <= '0;
			end else if (grant[p]) begin
				evt_cnt_reg <= evt_cfg_reg[p];
			end else if (ms_tick && evt_cnt_reg != 16'h0000) begin
				evt_cnt_reg <= evt_cnt_reg - 16'h0001;
			end
		end

		// Snapshot of last sent data
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				prev_reg <= '0;
			end else if (grant[p]) begin
				prev_reg <= tpdo_data_i[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit arbitration
	// lowest identifier first, heartbeat last
	always_comb begin
		sel_pdo = 2'h0;
		pdo_any = 1'b0;
		for (int i = NPDO - 1; i >= 0; i--) begin
			if (rdy[i]) begin
				sel_pdo = 2'(i);
				pdo_any = 1'b1;
			end
		end
	end
	assign load = node_ok && (!tx_valid_o || tx_ready_i) && (pdo_any || hb_pend_reg);
	assign hb_grant = load && !pdo_any;

	// Output frame register
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_valid_o <= 1'b0;
			tx_frame_o <= '0;
		end else if (load) begin
			tx_valid_o <= 1'b1;
			if (pdo_any) begin
				tx_frame_o.id <= {4'(FC_TPDO1 + {1'b0, sel_pdo, 1'b0}), node_reg};
				tx_frame_o.dlc <= MAX_DLC;
				tx_frame_o.data <= tpdo_data_i[sel_pdo];
			end else begin
				tx_frame_o.id <= {FC_HB, node_reg};
				tx_frame_o.dlc <= 4'h1;
				tx_frame_o.data <= {56'h0, state_code};
			end
		end else if (tx_ready_i) begin
			tx_valid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Heartbeat producer
	assign hb_due = state_reg != NS_INIT && ms_tick && hbp_reg != 16'h0000 &&
		({1'b0, hb_cnt_reg} + 17'h00001 >= {1'b0, hbp_reg});
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hb_cnt_reg <= '0;
		end else if (state_reg == NS_INIT || hb_due) begin
			hb_cnt_reg <= '0;
		end else if (ms_tick && hbp_reg != 16'h0000) begin
			hb_cnt_reg <= hb_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hb_pend_reg <= 1'b0;
		end else if (state_reg == NS_INIT) begin
			hb_pend_reg <= !hb_grant;
		end else begin
			hb_pend_reg <= (hb_pend_reg && !hb_grant) || hb_due;
		end
	end

	////////////////////////////////////////////////////////////////
	// Master heartbeat supervision
	assign mhb_hit = rx_valid_i && rx_frame_i.id == {FC_HB, master_reg} && rx_frame_i.dlc != 4'h0;
	assign cons_expire = cons_armed_reg && hbc_reg != 16'h0000 && cons_cnt_reg >= hbc_reg;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cons_armed_reg <= 1'b0;
			cons_cnt_reg <= '0;
		end else if (mhb_hit) begin
			cons_armed_reg <= 1'b1;
			cons_cnt_reg <= '0;
		end else if (cons_armed_reg && ms_tick && hbc_reg != 16'h0000 && cons_cnt_reg != 16'hFFFF) begin
			cons_cnt_reg <= cons_cnt_reg + 16'h0001;
		end
	end

	// sticky error, set wins over clear
	assign status_clr = reg_wr_i && reg_addr_i == A_STATUS && reg_wdata_i[STAT_CERR_BIT];
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			comm_err_reg <= 1'b0;
		end else begin
			comm_err_reg <= cons_expire || (comm_err_reg && !status_clr);
		end
	end

	// alarm and stop in stop mode
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			alarm_reg <= 1'b0;
		end else begin
			alarm_reg <= comm_err_reg && stop_en_reg;
		end
	end
	assign comm_err_o = comm_err_reg;
	assign alarm_o = alarm_reg;
	assign stop_o = alarm_reg;

	////////////////////////////////////////////////////////////////
	// Receive PDOs
	assign rfc = rx_frame_i.id[10:7];
	assign roff = rfc - FC_RPDO1;
	assign ridx = roff[2:1];
	assign rpdo_hit = rx_valid_i && node_ok && is_oper && rx_frame_i.id[6:0] == node_reg &&
		rfc >= FC_RPDO1 && rfc <= FC_RPDO4 && !rfc[0] && rx_frame_i.dlc <= MAX_DLC;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rpdo_upd_o <= '0;
			rpend_reg <= '0;
			rpdo_data_o <= '0;
			for (int i = 0; i < NPDO; i++) begin
				rbuf_reg[i] <= '0;
			end
		end else begin
			rpdo_upd_o <= '0;
			// apply captured data at update point
			for (int i = 0; i < NPDO; i++) begin
				if (interp_reg && interp_point_i && rpend_reg[i]) begin
					rpdo_data_o[i] <= rbuf_reg[i];
					rpdo_upd_o[i] <= 1'b1;
					rpend_reg[i] <= 1'b0;
				end
			end
			if (rpdo_hit && !interp_reg) begin
				rpdo_data_o[ridx] <= rx_frame_i.data;
				rpdo_upd_o[ridx] <= 1'b1;
			end else if (rpdo_hit) begin
				rbuf_reg[ridx] <= rx_frame_i.data;
				rpend_reg[ridx] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_boot_sent;
		hb_grant && state_reg == NS_INIT;
	endsequence
	sequence s_boot_frame;
		state_reg == NS_PREOP && tx_valid_o && tx_frame_o.data[7:0] == ST_BOOT;
	endsequence
	property p_boot;
		s_boot_sent |=> s_boot_frame;
	endproperty
	a_boot: assert property (p_boot) else $error("boot-up frame missing");
	property p_preop;
		s_boot_sent |=> state_reg == NS_PREOP ##1 state_reg != NS_INIT;
	endproperty
	a_preop: assert property (p_preop) else $error("no pre-operational entry");
	property p_hb_id;
		tx_valid_o && tx_frame_o.id[10:7] == FC_HB |-> tx_frame_o.id[6:0] == node_reg && tx_frame_o.dlc == 4'h1;
	endproperty
	a_hb_id: assert property (p_hb_id) else $error("bad heartbeat frame");
	property p_len;
		tx_valid_o |-> tx_frame_o.dlc <= MAX_DLC && tx_frame_o.id[6:0] != 7'h00;
	endproperty
	a_len: assert property (p_len) else $error("bad length or node");
	property p_tpdo_id;
		grant[1] |=> tx_valid_o && tx_frame_o.id == {4'h5, node_reg};
	endproperty
	a_tpdo_id: assert property (p_tpdo_id) else $error("bad transmit identifier");
	property p_inh;
		grant[0] && inh_cfg_reg[0] != 16'h0000 |=> !grant[0] && inh_cnt_reg[0] == {1'b0, inh_cfg_reg[0]} + 17'h00001;
	endproperty
	a_inh: assert property (p_inh) else $error("inhibit not restarted");
	property p_cerr;
		cons_expire |=> comm_err_o ##1 (alarm_o == stop_en_reg);
	endproperty
	a_cerr: assert property (p_cerr) else $error("timeout not flagged");
	property p_stop;
		!comm_err_reg |=> !stop_o;
	endproperty
	a_stop: assert property (p_stop) else $error("stop without error");
	property p_rx_now;
		rpdo_hit && !interp_reg |=> rpdo_upd_o[$past(ridx)] && rpdo_data_o[$past(ridx)] == $past(rx_frame_i.data);
	endproperty
	a_rx_now: assert property (p_rx_now) else $error("receive data not applied");
	property p_rx_hold;
		interp_reg && !interp_point_i |=> rpdo_upd_o == '0 || $past(rpdo_hit && !interp_reg);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("update outside point");
endmodule

// file: inc/cpn_pkg.sv
package cpn_pkg;
	// Clock and millisecond base
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned MS_US = 1000;
	localparam int unsigned MS_CYCLES = CLK_MHZ * MS_US;
	localparam int NPDO = 4;
	localparam logic [3:0] MAX_DLC = 4'h8;
	// Function codes and fixed identifiers
	localparam logic [3:0] FC_TPDO1 = 4'h3;
	localparam logic [3:0] FC_RPDO1 = 4'h4;
	localparam logic [3:0] FC_RPDO4 = 4'hA;
	localparam logic [3:0] FC_HB = 4'hE;
	localparam logic [10:0] ID_SYNC = 11'h080;
	// Heartbeat state codes
	localparam logic [7:0] ST_BOOT = 8'h00;
	localparam logic [7:0] ST_STOP = 8'h04;
	localparam logic [7:0] ST_OPER = 8'h05;
	localparam logic [7:0] ST_PREOP = 8'h7F;
	// Transmission types
	localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
	localparam logic [7:0] TT_ASYNC = 8'hFE;
	// Register addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATE = 8'h01;
	localparam logic [7:0] A_HBP = 8'h02;
	localparam logic [7:0] A_HBC = 8'h03;
	localparam logic [7:0] A_MASTER = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h05;
	localparam logic [3:0] TPDO_PAGE = 4'h1;
	localparam logic [1:0] F_TYPE = 2'h0;
	localparam logic [1:0] F_INH = 2'h1;
	localparam logic [1:0] F_EVT = 2'h2;
	// Field positions
	localparam int CTRL_STOPEN_BIT = 7;
	localparam int CTRL_INTERP_BIT = 8;
	localparam int STAT_CERR_BIT = 8;
	// Reset values
	localparam logic [6:0] RST_NODE = 7'h01;
	localparam logic [6:0] RST_MASTER = 7'h7F;
	localparam logic [15:0] RST_HBP = 16'h03E8;
	localparam logic [15:0] RST_HBC = 16'h0000;
	localparam logic [7:0] RST_TTYPE = 8'hFF;
	// Frame carrier, byte 0 in data[7:0]
	typedef struct packed {
		logic [10:0] id;
		logic [3:0] dlc;
		logic [63:0] data;
	} cpn_frame_t;
	// Node states
	typedef enum logic [3:0] {
		NS_INIT = 4'b0001,
		NS_PREOP = 4'b0010,
		NS_OPER = 4'b0100,
		NS_STOP = 4'b1000
	} cpn_nstate_t;
endpackage

// file: tb/cpn_master_model.sv
`timescale 1ns/1ps
module cpn_master_model #(
	parameter int unsigned SYNC_GAP = 20,
	parameter int unsigned HB_WAIT = 40000
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Frames towards the node
	output logic rx_valid_o,
	output cpn_pkg::cpn_frame_t rx_frame_o,
	// Frames from the node
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire cpn_pkg::cpn_frame_t tx_frame_i,
	// Control and status
	input wire logic stall_i,
	output logic node_alarm_o
);
	import cpn_pkg::*;
	cpn_frame_t got_q[$];
	int unsigned hb_cnt;

	////////////////////////////////////////////////////////////////
	// Idle bus at start
	initial begin
		rx_valid_o = 1'b0;
		rx_frame_o = '0;
		tx_ready_o = 1'b0;
	end

	// Sink stalls on request
	always @(posedge ref_clk_i) begin
		tx_ready_o <= !stall_i;
	end

	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hb_cnt <= 0;
			node_alarm_o <= 1'b0;
		end else begin
			hb_cnt <= hb_cnt + 1;
			if (hb_cnt >= HB_WAIT) begin
				node_alarm_o <= 1'b1;
			end
			if (tx_valid_i && tx_ready_o) begin
				got_q.push_back(tx_frame_i);
				if (tx_frame_i.id[10:7] == FC_HB) begin
					hb_cnt <= 0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// at most eight bytes on agreed identifiers
	task automatic send(input logic [10:0] fid, input logic [3:0] fdlc, input logic [63:0] fdata);
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b1;
		rx_frame_o <= '{id: fid, dlc: (fdlc > MAX_DLC) ? MAX_DLC : fdlc, data: fdata};
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b0;
		rx_frame_o <= ~rx_frame_o;
	endtask

	// spaced sync on its system identifier
	task automatic sync(input int n);
		repeat (n) begin
			send(ID_SYNC, 4'h0, 64'h0);
			repeat (SYNC_GAP) @(posedge ref_clk_i);
		end
	endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cpn_pkg::*;
	localparam int unsigned MSC = 20;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
	} cpn_tb_row_t;
	logic ref_clk_i;
	logic arst_n_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [31:0] reg_rdata_o;
	logic rx_valid_i;
	cpn_frame_t rx_frame_i;
	logic tx_valid_o;
	logic tx_ready_i;
	cpn_frame_t tx_frame_o;
	logic [NPDO-1:0][63:0] tpdo_data_i;
	logic [NPDO-1:0][63:0] rpdo_data_o;
	logic interp_point_i;
	logic [NPDO-1:0] rpdo_upd_o;
	logic [7:0] node_state_o;
	logic comm_err_o;
	logic alarm_o;
	logic stop_o;
	logic stall;
	logic node_alarm;
	int fail_count;
	int num_checks;
	int n;
	int gap;
	time t0;
	logic [31:0] rd;
	cpn_frame_t f;
	cpn_tb_row_t rows [15] = '{
		'{1'b0, A_CTRL, 32'h00000001}, '{1'b0, A_HBP, 32'h000003E8}, '{1'b0, A_HBC, 32'h00000000},
		'{1'b0, A_MASTER, 32'h0000007F}, '{1'b0, 8'h10, 32'h000000FF}, '{1'b0, 8'h40, 32'h00000000},
		'{1'b0, A_STATUS, 32'h0000007F}, '{1'b1, A_STATE, 32'h00000009}, '{1'b0, A_STATE, 32'h0000007F},
		'{1'b1, A_STATE, 32'h00000004}, '{1'b0, A_STATE, 32'h00000004}, '{1'b1, A_STATE, 32'h00000005},
		'{1'b0, A_STATUS, 32'h00000005}, '{1'b1, A_HBP, 32'h00000000}, '{1'b0, A_HBP, 32'h00000000}};

	////////////////////////////////////////////////////////////////
	// Design and far side
	cpn_node #(.MS_CYC(MSC)) i_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
		.tx_frame_o(tx_frame_o), .tpdo_data_i(tpdo_data_i), .interp_point_i(interp_point_i),
		.rpdo_data_o(rpdo_data_o), .rpdo_upd_o(rpdo_upd_o), .node_state_o(node_state_o),
		.comm_err_o(comm_err_o), .alarm_o(alarm_o), .stop_o(stop_o));
	cpn_master_model #(.SYNC_GAP(MSC), .HB_WAIT(10 * MSC)) i_master (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.rx_valid_o(rx_valid_i), .rx_frame_o(rx_frame_i), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
		.tx_frame_i(tx_frame_o), .stall_i(stall), .node_alarm_o(node_alarm));

	// Clock at 200 MHz
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Register bus cycles
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	// Bounded wait for an accepted frame
	task automatic get_frame(output cpn_frame_t fr);
		int i;
		for (i = 0; i < 3000 && i_master.got_q.size() == 0; i++)
			@(posedge ref_clk_i);
		if (i_master.got_q.size() == 0) begin
			fail_count++;
			wrap_up();
		end else
			fr = i_master.got_q.pop_front();
	endtask

	function automatic logic [7:0] ta(input int p, input logic [1:0] fld);
		return {TPDO_PAGE, p[1:0], fld};
	endfunction

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{arst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, stall, interp_point_i} = '0;
		tpdo_data_i = '0;
		repeat (5) @(posedge ref_clk_i);
		check(node_state_o, ST_BOOT);
		check(tx_valid_o, 1'b0);
		arst_n_i <= 1'b1;
		get_frame(f);
		check(f.id, 11'h701);
		check({f.dlc, f.data[7:0]}, {4'h1, ST_BOOT});
		check(node_alarm, 1'b0);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				reg_wr(rows[i].a, rows[i].d);
			end else begin
				reg_rd(rows[i].a, rd);
				check(rd, rows[i].d);
			end
		end
		check(node_state_o, ST_OPER);
		// held sends leave lowest identifier first
		stall <= 1'b1;
		for (int p = 0; p < NPDO; p++) begin
			reg_wr(ta(p, F_TYPE), 32'h00000001);
			tpdo_data_i[p] <= {8{8'hA0 + p[7:0]}};
		end
		i_master.got_q.delete();
		i_master.sync(1);
		stall <= 1'b0;
		for (int p = 0; p < NPDO; p++) begin
			get_frame(f);
			check(f.id, {4'h3 + {p[2:0], 1'b0}, 7'h01});
			check(f.data, {8{8'hA0 + p[7:0]}});
		end
		reg_wr(ta(0, F_TYPE), 32'h00000002);
		for (int p = 1; p < NPDO; p++)
			reg_wr(ta(p, F_TYPE), 32'h000000F5);
		i_master.got_q.delete();
		i_master.sync(4);
		check(i_master.got_q.size(), 2);
		// change sends, inhibit holds the next
		reg_wr(ta(0, F_TYPE), {24'h0, TT_ASYNC});
		reg_wr(ta(0, F_INH), 32'h00000002);
		repeat (80) @(posedge ref_clk_i);
		i_master.got_q.delete();
		tpdo_data_i[0] <= 64'h1;
		get_frame(f);
		t0 = $time;
		check(f.data, 64'h1);
		tpdo_data_i[0] <= 64'h2;
		get_frame(f);
		gap = int'(($time - t0) / 5);
		check(f.data, 64'h2);
		check(gap >= 2 * MSC - 2 && gap <= 3 * MSC + 2, 1'b1);
		reg_wr(ta(0, F_INH), 32'h00000000);
		reg_wr(ta(0, F_EVT), 32'h00000003);
		get_frame(f);
		t0 = $time;
		get_frame(f);
		gap = int'(($time - t0) / 5);
		check(gap >= 2 * MSC && gap <= 4 * MSC, 1'b1);
		reg_wr(ta(0, F_EVT), 32'h00000000);
		reg_wr(ta(0, F_TYPE), 32'h000000F5);
		for (int p = 0; p < NPDO; p++) begin
			i_master.send({4'h4 + {p[2:0], 1'b0}, 7'h01}, 4'h8, {8{8'h50 + p[7:0]}});
			#1;
			check(rpdo_upd_o, 4'h1 << p);
			check(rpdo_data_o[p], {8{8'h50 + p[7:0]}});
		end
		// interpolation waits for the update point
		reg_wr(A_CTRL, 32'h00000101);
		i_master.send(11'h201, 4'h8, 64'h77);
		repeat (4) @(posedge ref_clk_i);
		check(rpdo_data_o[0], 64'h5050505050505050);
		interp_point_i <= 1'b1;
		@(posedge ref_clk_i);
		interp_point_i <= 1'b0;
		#1;
		check({rpdo_upd_o, rpdo_data_o[0]}, {4'h1, 64'h77});
		reg_wr(A_CTRL, 32'h00000080);
		reg_rd(A_STATUS, rd);
		check(rd[9], 1'b1);
		reg_wr(ta(0, F_TYPE), 32'h00000001);
		i_master.got_q.delete();
		i_master.sync(2);
		check(i_master.got_q.size(), 0);
		reg_wr(ta(0, F_TYPE), 32'h000000F5);
		reg_wr(A_CTRL, 32'h00000081);
		reg_wr(A_HBC, 32'h00000002);
		repeat (3) begin
			i_master.send(11'h77F, 4'h1, 64'h05);
			repeat (15) @(posedge ref_clk_i);
		end
		#1;
		check(comm_err_o, 1'b0);
		for (n = 15; n < 200 && comm_err_o !== 1'b1; n++) begin
			@(posedge ref_clk_i);
			#1;
		end
		check(n >= MSC && n <= 3 * MSC + 3, 1'b1);
		check(alarm_o, 1'b0);
		@(posedge ref_clk_i);
		#1;
		check({alarm_o, stop_o}, 2'b11);
		check(node_alarm, 1'b1);
		wrap_up();
	end
endmodule
